// >>> mssm_map.vh
// Register map and constants of the motor speed measurement timer
`ifndef MSSM_MAP_VH
`define MSSM_MAP_VH
`define MSSM_AW 4
`define MSSM_A_CNT_HI 4'h0
`define MSSM_A_CNT_LO 4'h1
`define MSSM_A_CAP_HI 4'h2
`define MSSM_A_CAP_LO 4'h3
`define MSSM_A_COMM 4'h4
`define MSSM_A_LIMIT 4'h5
`define MSSM_A_PRESC 4'h6
`define MSSM_A_CTRL 4'h7
`define MSSM_A_STAT 4'h8
`define MSSM_A_MASK 4'h9
`define MSSM_CTRL_CKE 0
`define MSSM_CTRL_RST 1
`define MSSM_CTRL_SWA 2
`define MSSM_CTRL_ECM 3
`define MSSM_CTRL_DIR 4
`define MSSM_CTRL_SEL_LO 5
`define MSSM_CTRL_SEL_HI 6
`define MSSM_ST_CAP 0
`define MSSM_ST_UP 1
`define MSSM_ST_DN 2
`define MSSM_ST_SPD 3
`define MSSM_ST_EMG 4
`define MSSM_SEL_NONE 2'h0
`define MSSM_SEL_TACHO 2'h1
`define MSSM_SEL_HALL 2'h2
`define MSSM_SEL_ENC 2'h3
`define MSSM_CNT_MAX 16'hffff
`define MSSM_CNT_LOW 16'h5500
`define MSSM_LIM_LO 8'hff
`define MSSM_PRESC_MAX 4'hf
`define MSSM_PRESC_MIN 4'h0
`define MSSM_ZERO8 8'h00
`define MSSM_ZERO16 16'h0000
`define MSSM_ONE4 4'h1
`define MSSM_ONE16 16'h0001
`endif

// >>> mssm_timer.v
// Motor speed measurement timer with auto-adjusting prescaler
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "mssm_map.vh"
`default_nettype none
module mssm_timer (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Register port
   input wire [`MSSM_AW-1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // Sensor side
   input wire tacho_i,
   input wire hall_edge_i,
   input wire enc_tick_i,
   input wire rtc_tick_i,
   input wire emergency_stop_input_i,
   // Events
   output reg capture_irq_o,
   output reg ratio_irq_o,
   output reg emergency_irq_o
);
   reg [7:0] counter_high_byte;
   reg [7:0] counter_low_byte;
   reg [7:0] capture_high_reg;
   reg [7:0] capture_low_reg;
   reg [7:0] commutation_compare_reg;
   reg [7:0] speed_limit_compare_reg;
   reg [3:0] step_prescaler;
   reg [6:0] ctrl;
   reg [4:0] stat;
   reg [4:0] mask;
   reg [3:0] pdiv;
   reg tacho_q;
   reg lo_lock;
   reg [7:0] next_rdata;

   wire cke = ctrl[`MSSM_CTRL_CKE];
   wire prst = ctrl[`MSSM_CTRL_RST];
   wire auto_switch_enable = ctrl[`MSSM_CTRL_SWA];
   wire [1:0] sensor_select = ctrl[`MSSM_CTRL_SEL_HI:`MSSM_CTRL_SEL_LO];
   wire cfg_mode = !prst && !cke;
   wire sw_mode = !prst && cke && sensor_select == `MSSM_SEL_NONE && !auto_switch_enable;
   wire asw_mode = !prst && cke && sensor_select == `MSSM_SEL_NONE && auto_switch_enable;
   wire spd_mode = !prst && cke && sensor_select != `MSSM_SEL_NONE;
   wire enc = sensor_select == `MSSM_SEL_ENC;
   wire [15:0] cnt = {counter_high_byte, counter_low_byte};

   function hit;
      input [`MSSM_AW-1:0] a;
      input [`MSSM_AW-1:0] r;
      begin
         hit = (a == r);
      end
   endfunction

   wire wr_cnt_hi = wr_i && hit(addr_i, `MSSM_A_CNT_HI);
   wire rd_cnt_hi = rd_i && hit(addr_i, `MSSM_A_CNT_HI);
   wire rd_cap_hi = rd_i && hit(addr_i, `MSSM_A_CAP_HI);
   wire rd_cap_lo = rd_i && hit(addr_i, `MSSM_A_CAP_LO);

   // Prescaled count tick: divide by 2^prescaler of the selected source for prescaler 0 to 4; 5 to 12 never tick, 13 to 15 tick undivided
   wire src_tick = enc ? enc_tick_i : 1'b1;
   wire [4:0] div_len = {1'b0, step_prescaler};
   wire [15:0] div_term = (`MSSM_ONE16 << div_len[3:0]) - `MSSM_ONE16;
   wire div_done = ({12'h000, pdiv} >= div_term) || (step_prescaler > 4'hc);
   wire cnt_tick = spd_mode && src_tick && div_done;

   // Capture trigger per sensor
   wire tacho_edge = tacho_i && !tacho_q;
   wire cap_trig = spd_mode && ((sensor_select == `MSSM_SEL_TACHO && tacho_edge) ||
                   (sensor_select == `MSSM_SEL_HALL && hall_edge_i) ||
                   (enc && (ctrl[`MSSM_CTRL_ECM] ? rd_cnt_hi : rtc_tick_i)));
   wire cap_take = cap_trig && !lo_lock;
   wire at_max = (cnt == `MSSM_CNT_MAX);
   wire ovf_up = cnt_tick && at_max && step_prescaler != `MSSM_PRESC_MAX;
   wire ovf_hold = at_max && step_prescaler == `MSSM_PRESC_MAX;
   wire dn_adj = cap_trig && cnt < `MSSM_CNT_LOW && step_prescaler != `MSSM_PRESC_MIN;
   wire spd_err = spd_mode && cnt > {speed_limit_compare_reg, `MSSM_LIM_LO};
   wire sw_step_dn = sw_mode && wr_i && hit(addr_i, `MSSM_A_STAT) && wdata_i[`MSSM_ST_DN];
   wire sw_step_up = sw_mode && wr_i && hit(addr_i, `MSSM_A_STAT) && wdata_i[`MSSM_ST_UP];

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         counter_high_byte <= `MSSM_ZERO8;
         counter_low_byte <= `MSSM_ZERO8;
         capture_high_reg <= `MSSM_ZERO8;
         capture_low_reg <= `MSSM_ZERO8;
         commutation_compare_reg <= `MSSM_ZERO8;
         speed_limit_compare_reg <= `MSSM_ZERO8;
         step_prescaler <= `MSSM_PRESC_MIN;
         ctrl <= 7'h00;
         stat <= 5'h00;
         mask <= 5'h00;
         pdiv <= 4'h0;
         tacho_q <= 1'b0;
         lo_lock <= 1'b0;
         rdata_o <= `MSSM_ZERO8;
         capture_irq_o <= 1'b0;
         ratio_irq_o <= 1'b0;
         emergency_irq_o <= 1'b0;
      end else begin
         tacho_q <= tacho_i;
         rdata_o <= rd_i ? next_rdata : `MSSM_ZERO8;
         // Prescaler divider restarts on each count so the step is exact
         if (!spd_mode || cnt_tick || !src_tick)
            pdiv <= (spd_mode && !cnt_tick && !src_tick) ? pdiv : 4'h0;
         else
            pdiv <= pdiv + 4'h1;
         // Counter path: only counter bytes change by hardware
         if (cap_trig) begin
            if (dn_adj)
               {counter_high_byte, counter_low_byte} <= `MSSM_ZERO16;
            else
               {counter_high_byte, counter_low_byte} <= `MSSM_ZERO16;
         end else if (ovf_up) begin
            {counter_high_byte, counter_low_byte} <= {1'b0, cnt[15:1]};
         end else if (cnt_tick && !ovf_hold) begin
            {counter_high_byte, counter_low_byte} <= cnt + `MSSM_ONE16;
         end else if (!spd_mode && !prst && cke && cnt_tick) begin
            counter_high_byte <= counter_high_byte;
         end else if (cfg_mode && wr_i) begin
            if (hit(addr_i, `MSSM_A_CNT_HI))
               counter_high_byte <= wdata_i;
            if (hit(addr_i, `MSSM_A_CNT_LO))
               counter_low_byte <= wdata_i;
         end
         // Capture registers
         if (cap_take) begin
            capture_high_reg <= counter_high_byte;
            capture_low_reg <= counter_low_byte;
         end else if (wr_i && !prst) begin
            if (hit(addr_i, `MSSM_A_CAP_HI))
               capture_high_reg <= wdata_i;
            if (hit(addr_i, `MSSM_A_CAP_LO))
               capture_low_reg <= wdata_i;
         end
         if (rd_cap_hi)
            lo_lock <= 1'b1;
         else if (rd_cap_lo)
            lo_lock <= 1'b0;
         // Compare registers, writable outside reset in every mode
         if (wr_i && !prst && hit(addr_i, `MSSM_A_COMM))
            commutation_compare_reg <= wdata_i;
         if (wr_i && !prst && hit(addr_i, `MSSM_A_LIMIT))
            speed_limit_compare_reg <= wdata_i;
         // Prescaler
         if (ovf_up)
            step_prescaler <= step_prescaler + `MSSM_ONE4;
         else if (dn_adj)
            step_prescaler <= step_prescaler - `MSSM_ONE4;
         else if (sw_step_up && step_prescaler != `MSSM_PRESC_MAX)
            step_prescaler <= step_prescaler + `MSSM_ONE4;
         else if (sw_step_dn && step_prescaler != `MSSM_PRESC_MIN)
            step_prescaler <= step_prescaler - `MSSM_ONE4;
         else if (cfg_mode && wr_i && hit(addr_i, `MSSM_A_PRESC))
            step_prescaler <= wdata_i[3:0];
         if (wr_i && hit(addr_i, `MSSM_A_CTRL))
            ctrl <= wdata_i[6:0];
         if (wr_i && hit(addr_i, `MSSM_A_MASK))
            mask <= wdata_i[4:0];
         // Sticky flags: write one clears except in software step mode, hardware set wins
         stat <= (stat & ~((wr_i && hit(addr_i, `MSSM_A_STAT) && !sw_mode) ? wdata_i[4:0] : 5'h00))
                 | {emergency_stop_input_i, spd_err, dn_adj, ovf_up, cap_take};
         capture_irq_o <= stat[`MSSM_ST_CAP] && mask[`MSSM_ST_CAP];
         ratio_irq_o <= (stat[`MSSM_ST_UP] || stat[`MSSM_ST_DN]) && mask[`MSSM_ST_UP];
         emergency_irq_o <= (stat[`MSSM_ST_SPD] && mask[`MSSM_ST_SPD]) ||
                            (stat[`MSSM_ST_EMG] && mask[`MSSM_ST_EMG]);
      end
   end

   // Read mux; capture low shows capture_low_reg, which captures leave unchanged while the lock stands
   always @* begin
      case (addr_i)
         `MSSM_A_CNT_HI: next_rdata = counter_high_byte;
         `MSSM_A_CNT_LO: next_rdata = counter_low_byte;
         `MSSM_A_CAP_HI: next_rdata = capture_high_reg;
         `MSSM_A_CAP_LO: next_rdata = capture_low_reg;
         `MSSM_A_COMM: next_rdata = commutation_compare_reg;
         `MSSM_A_LIMIT: next_rdata = speed_limit_compare_reg;
         `MSSM_A_PRESC: next_rdata = {4'h0, step_prescaler};
         `MSSM_A_CTRL: next_rdata = {1'b0, ctrl};
         `MSSM_A_STAT: next_rdata = {3'h0, stat};
         `MSSM_A_MASK: next_rdata = {3'h0, mask};
         default: next_rdata = `MSSM_ZERO8;
      endcase
   end
   wire unused_ok = wr_cnt_hi;
endmodule // mssm_timer
`default_nettype wire

// >>> mssm_timer_assertions.sv
// Port checker of the speed measurement timer
`default_nettype none
module mssm_chk (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic tacho_i,
   input wire logic emergency_stop_input_i,
   input wire logic capture_irq_o,
   input wire logic ratio_irq_o,
   input wire logic emergency_irq_o
);
   logic [7:0] msk, ctl;
   logic lck;
   wire logic clr = wr_i && addr_i == 4'h8 && wdata_i[0];
   // Mask, control and lock shadows rebuilt from bus traffic
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         msk <= 8'h00;
         ctl <= 8'h00;
         lck <= 1'b0;
      end else begin
         if (wr_i && addr_i == 4'h9) msk <= wdata_i;
         if (wr_i && addr_i == 4'h7) ctl <= wdata_i;
         if (rd_i && addr_i[3:1] == 3'h1) lck <= !addr_i[0];
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside slot");
   a_rd_unmapped: assert property (rd_i && addr_i > 4'h9 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_cap_mask: assert property (!msk[0] && !$past(msk[0]) |-> !capture_irq_o)
      else $error("masked capture seen");
   a_ratio_mask: assert property (!msk[1] && !$past(msk[1]) |-> !ratio_irq_o)
      else $error("masked ratio seen");
   a_emg_mask: assert property (msk[4:3] == 2'b00 && $past(msk[4:3]) == 2'b00 |-> !emergency_irq_o)
      else $error("masked emergency seen");
   a_emg_event: assert property (emergency_stop_input_i && msk[4] && $past(msk[4]) |-> ##[1:3] emergency_irq_o)
      else $error("emergency not raised");
   a_tacho_cap: assert property ($rose(tacho_i) && ctl[6:0] == 7'h21 && msk[0] && !lck |-> ##[1:4] capture_irq_o)
      else $error("tacho edge not captured");
   a_cap_sticky: assert property (capture_irq_o && msk[0] && !$past(clr) |=> capture_irq_o)
      else $error("capture flag dropped");
   c_capture: cover property (capture_irq_o);
   c_ratio: cover property (ratio_irq_o);
   c_emergency: cover property (emergency_irq_o);
endmodule // mssm_chk
bind mssm_timer mssm_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tacho_i(tacho_i), .emergency_stop_input_i(emergency_stop_input_i),
   .capture_irq_o(capture_irq_o), .ratio_irq_o(ratio_irq_o), .emergency_irq_o(emergency_irq_o));
`default_nettype wire

// >>> mssm_sensor_model.sv
// Sensor side: tacho wave, hall pulses, encoder and RTC ticks
`default_nettype none
module mssm_sensor_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] period_i,
   output logic tacho_o,
   output logic hall_edge_o,
   output logic enc_tick_o,
   output logic rtc_tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt;
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) cnt <= 16'h0000;
      else cnt <= (cnt >= period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
   end
   // Rising edge once per period, so a period change shows up cleanly
   assign tacho_o = cnt < {1'b0, period_i[15:1]};
   assign hall_edge_o = cnt == 16'h0000 || cnt == {1'b0, period_i[15:1]};
   assign enc_tick_o = cnt[0];
   assign rtc_tick_o = cnt[7:0] == 8'h00;
endmodule // mssm_sensor_model
`default_nettype wire

// >>> mssm_timer_tb.sv
// Self-checking bench of the speed measurement timer
`default_nettype none
module mssm_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, emg = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, d, q, h, l;
   logic tacho, hall, enc, rtc, cap_irq, rat_irq, emg_irq;
   logic [15:0] period = 16'd300;
   int fails = 0, checked = 0, i, n;
   always #5 ref_clk_i = ~ref_clk_i;
   mssm_sensor_model mdl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .period_i(period), .tacho_o(tacho),
      .hall_edge_o(hall), .enc_tick_o(enc), .rtc_tick_o(rtc));
   mssm_timer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .tacho_i(tacho), .hall_edge_i(hall), .enc_tick_i(enc), .rtc_tick_i(rtc),
      .emergency_stop_input_i(emg), .capture_irq_o(cap_irq), .ratio_irq_o(rat_irq), .emergency_irq_o(emg_irq));
   task automatic complete_run(input logic timeout);
      if (timeout) fails++;
      $display("Checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   function automatic logic near(input logic [15:0] v, input int e);
      return v + 4 >= e && v <= e + 4;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      v = rdata_o;
   endtask
   // Clock off, counter loaded, prescaler set, flags cleared, then mode
   task automatic cfg(input logic [7:0] hi, input logic [7:0] p, input logic [7:0] mode);
      wr(7, 8'h00);
      wr(0, hi);
      wr(1, 8'h00);
      wr(6, p);
      wr(8, 8'h1f);
      wr(7, mode);
   endtask
   task automatic wait_cap();
      // Let a just-written flag clear reach the output before polling
      repeat (2) @(negedge ref_clk_i);
      for (n = 0; n < 3000 && cap_irq !== 1'b1; n++) @(negedge ref_clk_i);
      if (n == 3000) complete_run(1'b1);
   endtask
   initial begin
      void'($urandom(32'hc89b));
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 7; i++) begin
         d = 8'($urandom);
         wr(i[3:0], d);
         rd(i[3:0], q);
         chk(q, (i == 6) ? d & 8'h0f : d);
      end
      rd(4'hf, q);
      chk(q, 8'h00);
      wr(6, 8'h05);
      wr(7, 8'h01);
      wr(6, 8'h09);
      rd(6, q);
      chk(q, 8'h05);
      wr(8, 8'h04);
      rd(6, q);
      chk(q, 8'h04);
      wr(8, 8'h02);
      wr(8, 8'h00);
      rd(6, q);
      chk(q, 8'h05);
      $display("access modes done");
      wr(5, 8'h00);
      wr(9, 8'h1b);
      cfg(8'h00, 8'h01, 8'h21);
      wait_cap();
      wr(6, 8'h09);
      rd(6, q);
      chk(q, 8'h00);
      rd(8, q);
      chk(q[2:0], 3'b101);
      chk(rat_irq, 1'b1);
      wr(8, 8'h1f);
      wait_cap();
      rd(8, q);
      chk(q[3:2], 2'b10);
      chk(emg_irq, 1'b1);
      rd(2, h);
      period <= 16'd450;
      repeat (1000) @(posedge ref_clk_i);
      rd(3, l);
      chk(near({h, l}, 300), 1'b1);
      for (i = 0; i < 2; i++) begin
         wr(8, 8'h1f);
         wait_cap();
      end
      rd(2, h);
      rd(3, l);
      chk(near({h, l}, 450), 1'b1);
      emg <= 1'b1;
      @(posedge ref_clk_i);
      emg <= 1'b0;
      rd(8, q);
      chk(q[4], 1'b1);
      $display("tacho done");
      period <= 16'hffff;
      for (i = 0; i < 2; i++) begin
         cfg(8'hff, 8'h0e + i[7:0], 8'h21);
         repeat (400) @(posedge ref_clk_i);
         rd(6, q);
         chk(q, 8'h0f);
         rd(8, q);
         chk(q[1], i == 0);
         if (i == 1) begin
            rd(1, q);
            chk(q, 8'hff);
         end
      end
      $display("overflow done");
      for (i = 0; i < 2; i++) begin
         cfg(8'h00, 8'h00, i ? 8'h79 : 8'h71);
         repeat (40) @(posedge ref_clk_i);
         if (i == 1) rd(0, q);
         wait_cap();
         rd(2, h);
         rd(3, l);
         chk(h < 8'h80, 1'b1);
      end
      $display("encoder done");
      complete_run(1'b0);
   end
endmodule // mssm_timer_tb
`default_nettype wire
